// ==== safc_decode_model.sv ====
// Decode-side model: presents one instruction at a time to the checker.
// Assumes a single bench process calls issue and clocks run from sys_clk.
`timescale 1ns/1ns
module safc_decode_model (
  input wire logic sys_clk,
  output logic req_valid,
  output logic req_ext_prefix,
  output logic req_vlen256,
  output safc_pkg::safc_class_e req_class,
  output logic [2:0] req_size_log2,
  output logic [63:0] req_addr,
  output logic [1:0] req_ring,
  output logic alignment_check_flag,
  output safc_pkg::safc_fpkind_e req_fp_kind,
  output logic [5:0] req_fp_flags,
  output logic [5:0] req_fp_masks,
  output logic req_wr_en,
  output logic [3:0] req_wr_idx,
  output logic [255:0] req_wr_data
);
  // ==========================================================
  // Idle lines at time zero
  initial begin
    req_class = safc_pkg::CLS_NONE;
    req_fp_kind = safc_pkg::FPK_NONE;
    {req_valid, req_ext_prefix, req_vlen256, req_size_log2, req_addr, req_ring} = '0;
    {alignment_check_flag, req_fp_flags, req_fp_masks, req_wr_en, req_wr_idx, req_wr_data} = '0;
  end

  // ==========================================================
  // One instruction for one enabled edge, then released
  task automatic issue(input logic ext, input logic v256, input safc_pkg::safc_class_e cls,
    input logic [2:0] sz, input logic [63:0] a, input logic [1:0] ring, input logic acf,
    input safc_pkg::safc_fpkind_e fk, input logic [5:0] ff, input logic [5:0] fm,
    input logic we, input logic [255:0] wd);
    @(posedge sys_clk);
    req_valid <= 1'h1;
    req_ext_prefix <= ext;
    req_vlen256 <= v256;
    req_class <= cls;
    req_size_log2 <= sz;
    req_addr <= a;
    req_ring <= ring;
    alignment_check_flag <= acf;
    req_fp_kind <= fk;
    req_fp_flags <= ff;
    req_fp_masks <= fm;
    req_wr_en <= we;
    req_wr_idx <= 4'h2;
    req_wr_data <= wd;
    @(posedge sys_clk);
    req_valid <= 1'h0;
    req_wr_en <= 1'h0;
    // Stale address and data lines flip so nothing leans on their held values
    req_addr <= ~a;
    req_wr_data <= ~wd;
    @(negedge sys_clk);
  endtask
endmodule

// ==== safc_pkg.sv ====
// Shared constants and enumerations for the SIMD alignment fault checker.
// Assumes an APB slave with 32-bit data and byte addresses.
package safc_pkg;

  // ==========================================================
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00; // Control flags
  localparam logic [7:0] REG_XMASK = 8'h04; // Extended-state enable mask
  localparam logic [7:0] REG_STATUS = 8'h08; // Last fault and fault count
  localparam logic [7:0] REG_FEATURE = 8'h0C; // Feature query window

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_AM_BIT = 0; // alignment_mask_ctrl
  localparam int CTRL_OSFP_BIT = 10; // os_simd_fp_handler_flag
  localparam int XMASK_W = 3; // Implemented mask width
  localparam logic [2:0] XMASK_RESET = 3'h1; // Only base state enabled
  localparam int XMASK_NARROW_BIT = 1; // Narrow vector state enable
  localparam int XMASK_WIDE_BIT = 2; // Wide vector state enable
  localparam int FEAT_LEAF_LSB = 0; // Query leaf select, 8 bits
  localparam int FEAT_SUB_LSB = 8; // Query subleaf select, 8 bits
  localparam int STAT_GP_BIT = 0;
  localparam int STAT_AC_BIT = 1;
  localparam int STAT_UD_BIT = 2;
  localparam int STAT_XM_BIT = 3;
  localparam int STAT_CNT_LSB = 8; // Saturating fault count, 8 bits

  // ==========================================================
  // Feature query and architectural values
  localparam logic [31:0] FEAT_LEAF = 32'h0000_0007; // Extended feature leaf
  localparam logic [31:0] FEAT_SUBLEAF = 32'h0000_0000;
  localparam int FEAT_WIDE_INT_BIT = 5; // Wide integer vector support
  localparam logic [1:0] RING_USER = 2'h3; // Least privileged ring
  localparam logic [15:0] ERR_CODE_ZERO = 16'h0000; // Code for GP and AC
  localparam logic [2:0] SIZE_16 = 3'h4; // log2 of 16 bytes
  localparam logic [2:0] SIZE_32 = 3'h5; // log2 of 32 bytes
  localparam logic [2:0] SIZE_8 = 3'h3; // log2 of 8 bytes
  localparam int FP_FLAG_W = 6; // SIMD FP exception flags
  localparam int NARROW_W = 128; // Narrow alias width
  localparam int WIDE_W = 256; // Wide vector width

  // ==========================================================
  // Decode classes
  typedef enum logic [2:0] {
    CLS_NONE, // No memory operand
    CLS_ALIGNED_MOVE, // Explicitly aligned move or non-temporal store
    CLS_NT_LOAD, // nontemporal_aligned_load
    CLS_UNALIGNED_MOVE, // Explicitly unaligned move
    CLS_ARITH, // Arithmetic or data-processing operand
    CLS_SCALAR // 2, 4 or 8-byte reference
  } safc_class_e;

  typedef enum logic [2:0] {
    FPK_NONE, // No floating-point result
    FPK_VECTOR, // Vector floating-point arithmetic
    FPK_HALFCONV, // Half-precision conversion
    FPK_FUSED, // Fused multiply-add
    FPK_INT_DATA // FP data moved by wide integer extension
  } safc_fpkind_e;

endpackage

// ==== safc_top.sv ====
// SIMD alignment and floating-point fault checker with vector register file.
// Assumes decode presents one instruction per enabled cycle on synchronous
// inputs and that software reaches the control registers over APB.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns

module safc_top #(
  parameter int NREGS = 16,
  parameter int ADDR_W = 64
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction from decode
  input wire logic req_valid,
  input wire logic req_ext_prefix,
  input wire logic req_vlen256,
  input wire safc_pkg::safc_class_e req_class,
  input wire logic [2:0] req_size_log2,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_ring,
  input wire logic alignment_check_flag,
  input wire safc_pkg::safc_fpkind_e req_fp_kind,
  input wire logic [safc_pkg::FP_FLAG_W-1:0] req_fp_flags,
  input wire logic [safc_pkg::FP_FLAG_W-1:0] req_fp_masks,
  input wire logic req_wr_en,
  input wire logic [$clog2(NREGS)-1:0] req_wr_idx,
  input wire logic [safc_pkg::WIDE_W-1:0] req_wr_data,
  // Register read port
  input wire logic [$clog2(NREGS)-1:0] rd_idx,
  output logic [safc_pkg::WIDE_W-1:0] rd_data,
  // Feature query port
  input wire logic query_valid,
  input wire logic [31:0] query_leaf,
  input wire logic [31:0] query_subleaf,
  output logic [31:0] query_ebx,
  output logic query_done,
  // Fault answers, one cycle after the request
  output logic fault_valid,
  output logic general_protection_fault,
  output logic alignment_check_fault,
  output logic undefined_opcode_fault,
  output logic simd_fp_exception,
  output logic [15:0] fault_error_code,
  output logic mem_go,
  output logic atomic_ok,
  output logic wr_done
);

  localparam int IDX_W = $clog2(NREGS);

  // ==========================================================
  // State
  typedef struct packed {
    logic pready; // APB access acknowledge
    logic pslverr; // Unmapped address answer
    logic [31:0] prdata; // APB read data
    logic amctrl; // alignment_mask_ctrl
    logic osfp; // os_simd_fp_handler_flag
    logic [safc_pkg::XMASK_W-1:0] xmask; // ext_state_enable_mask
    logic [7:0] sel_leaf; // Feature window leaf
    logic [7:0] sel_sub; // Feature window subleaf
    logic [3:0] last_fault; // Kind of the newest fault
    logic [7:0] fault_cnt; // Saturating fault counter
    logic fault_valid;
    logic gp;
    logic ac;
    logic ud;
    logic xm;
    logic [15:0] err_code;
    logic mem_go;
    logic atomic_ok;
    logic wr_done;
    logic [31:0] query_ebx;
    logic query_done;
    logic [safc_pkg::WIDE_W-1:0] rdata; // Read port data
    logic [NREGS-1:0][safc_pkg::WIDE_W-1:0] vreg; // Wide vector registers
  } safc_state_s;

  safc_state_s s;
  safc_state_s next_s;

  // ==========================================================
  // Functions
  // Feature word for a query; the same answer goes to APB and the port
  function automatic logic [31:0] feature_ebx(input logic [31:0] leaf,
                                              input logic [31:0] sub);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (leaf == safc_pkg::FEAT_LEAF && sub == safc_pkg::FEAT_SUBLEAF) begin
      w[safc_pkg::FEAT_WIDE_INT_BIT] = 1'b1;
    end
    return w;
  endfunction

  // Low address bits that must be zero for a natural alignment
  function automatic logic [4:0] size_mask(input logic [2:0] lg);
    logic [4:0] m;
    m = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (i < int'(lg)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ==========================================================
  // Fault decode
  logic mis16; // Low four address bits nonzero
  logic mis32; // Low five address bits nonzero
  logic missz; // Misaligned to the access size
  logic small_ref; // 2, 4 or 8-byte reference
  logic xstate_off; // Narrow and wide state both disabled by software
  logic nt_wide; // Non-temporal load has no 256-bit form
  logic gp_dec;
  logic ac_dec;
  logic fp_raise;
  logic ud_any;
  logic gp_f;
  logic ac_f;
  logic xm_f;
  logic fault;
  logic wr_ok;
  logic [safc_pkg::WIDE_W-1:0] wr_old; // Destination before the write
  logic [safc_pkg::WIDE_W-1:0] wr_merged; // Destination after the write

  assign mis16 = |req_addr[3:0];
  assign mis32 = |req_addr[4:0];
  assign missz = |(req_addr[4:0] & size_mask(req_size_log2));
  assign small_ref = (req_size_log2 != 3'h0) && (req_size_log2 <= safc_pkg::SIZE_8);

  assign xstate_off = req_ext_prefix
    && !s.xmask[safc_pkg::XMASK_WIDE_BIT] && !s.xmask[safc_pkg::XMASK_NARROW_BIT];
  assign nt_wide = req_ext_prefix && req_vlen256 && (req_class == safc_pkg::CLS_NT_LOAD);

  // Protection fault per class; unaligned moves never fault here
  always_comb begin
    gp_dec = 1'b0;
    case (req_class)
      safc_pkg::CLS_ALIGNED_MOVE, safc_pkg::CLS_NT_LOAD: begin
        gp_dec = (req_ext_prefix && req_vlen256) ? mis32 : mis16;
      end
      safc_pkg::CLS_ARITH: begin
        gp_dec = !req_ext_prefix && (req_size_log2 == safc_pkg::SIZE_16) && mis16;
      end
      safc_pkg::CLS_UNALIGNED_MOVE: begin
        gp_dec = 1'b0;
      end
      default: begin
        gp_dec = 1'b0;
      end
    endcase
  end

  assign ac_dec = small_ref && missz && alignment_check_flag
    && (req_ring == safc_pkg::RING_USER) && s.amctrl;

  assign fp_raise = ((req_fp_kind == safc_pkg::FPK_VECTOR)
    || (req_fp_kind == safc_pkg::FPK_HALFCONV) || (req_fp_kind == safc_pkg::FPK_FUSED))
    && |(req_fp_flags & ~req_fp_masks);

  // Priority undefined, protection, alignment, then floating point
  // no handler means undefined
  assign ud_any = xstate_off || nt_wide || (fp_raise && !s.osfp);
  assign gp_f = !ud_any && gp_dec;
  assign ac_f = !ud_any && !gp_dec && ac_dec;
  assign xm_f = !ud_any && !gp_dec && !ac_dec && fp_raise && s.osfp;
  assign fault = ud_any || gp_dec || ac_dec || fp_raise;

  assign wr_ok = req_valid && req_wr_en && !fault;
  assign wr_old = s.vreg[req_wr_idx];

  // Merge of the destination by encoding and vector length
  always_comb begin
    if (!req_ext_prefix) begin
      wr_merged = {wr_old[safc_pkg::WIDE_W-1:safc_pkg::NARROW_W],
                   req_wr_data[safc_pkg::NARROW_W-1:0]};
    end else if (req_vlen256) begin
      wr_merged = req_wr_data;
    end else begin
      wr_merged = {{safc_pkg::NARROW_W{1'b0}}, req_wr_data[safc_pkg::NARROW_W-1:0]};
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    // APB: one wait state, ready is a pulse in the second access cycle
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        safc_pkg::REG_CTRL: begin
          if (pwrite) begin
            next_s.amctrl = pwdata[safc_pkg::CTRL_AM_BIT];
            next_s.osfp = pwdata[safc_pkg::CTRL_OSFP_BIT];
          end else begin
            next_s.prdata[safc_pkg::CTRL_AM_BIT] = s.amctrl;
            next_s.prdata[safc_pkg::CTRL_OSFP_BIT] = s.osfp;
          end
        end
        safc_pkg::REG_XMASK: begin
          if (pwrite) begin
            next_s.xmask = pwdata[safc_pkg::XMASK_W-1:0];
          end else begin
            next_s.prdata[safc_pkg::XMASK_W-1:0] = s.xmask;
          end
        end
        safc_pkg::REG_STATUS: begin
          // Read only; writes are ignored
          if (!pwrite) begin
            next_s.prdata[3:0] = s.last_fault;
            next_s.prdata[safc_pkg::STAT_CNT_LSB +: 8] = s.fault_cnt;
          end
        end
        safc_pkg::REG_FEATURE: begin
          if (pwrite) begin
            next_s.sel_leaf = pwdata[safc_pkg::FEAT_LEAF_LSB +: 8];
            next_s.sel_sub = pwdata[safc_pkg::FEAT_SUB_LSB +: 8];
          end else begin
            next_s.prdata = feature_ebx({24'h000000, s.sel_leaf}, {24'h000000, s.sel_sub});
          end
        end
        default: begin
          // Unmapped: error answer, reads zero
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // Feature query port
    next_s.query_done = query_valid;
    next_s.query_ebx = query_valid ? feature_ebx(query_leaf, query_subleaf) : 32'h0000_0000;
    // Fault answers, cleared when no request
    next_s.fault_valid = req_valid && fault;
    next_s.ud = req_valid && ud_any;
    next_s.gp = req_valid && gp_f;
    next_s.ac = req_valid && ac_f;
    next_s.xm = req_valid && xm_f;
    next_s.err_code = safc_pkg::ERR_CODE_ZERO;
    next_s.mem_go = req_valid && (req_class != safc_pkg::CLS_NONE) && !fault;
    next_s.atomic_ok = req_valid && (req_class != safc_pkg::CLS_NONE) && !fault
      && (req_size_log2 <= safc_pkg::SIZE_8) && !missz;
    next_s.wr_done = wr_ok;
    if (req_valid && fault) begin
      next_s.last_fault = 4'h0;
      next_s.last_fault[safc_pkg::STAT_GP_BIT] = gp_f;
      next_s.last_fault[safc_pkg::STAT_AC_BIT] = ac_f;
      next_s.last_fault[safc_pkg::STAT_UD_BIT] = ud_any;
      next_s.last_fault[safc_pkg::STAT_XM_BIT] = xm_f;
      if (s.fault_cnt != 8'hFF) begin
        next_s.fault_cnt = s.fault_cnt + 8'h01;
      end
    end
    if (wr_ok) begin
      next_s.vreg[req_wr_idx] = wr_merged;
    end
    // Read sees the value before a same-cycle write
    next_s.rdata = s.vreg[rd_idx];
  end

  // ==========================================================
  // State register; clock enable freezes everything
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.xmask <= safc_pkg::XMASK_RESET;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rd_data = s.rdata;
  assign query_ebx = s.query_ebx;
  assign query_done = s.query_done;
  assign fault_valid = s.fault_valid;
  assign general_protection_fault = s.gp;
  assign alignment_check_fault = s.ac;
  assign undefined_opcode_fault = s.ud;
  assign simd_fp_exception = s.xm;
  assign fault_error_code = s.err_code;
  assign mem_go = s.mem_go;
  assign atomic_ok = s.atomic_ok;
  assign wr_done = s.wr_done;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic [IDX_W-1:0] wr_idx_q; // Write index sampled on the previous cycle, written or not
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_idx_q <= '0;
    end else begin
      wr_idx_q <= req_wr_idx;
    end
  end

  sequence s_take;
    clk_en && req_valid;
  endsequence

  sequence s_ext_narrow_wr;
    s_take ##0 (req_ext_prefix && !req_vlen256 && wr_ok);
  endsequence

  sequence s_legacy_wr;
    s_take ##0 (!req_ext_prefix && wr_ok);
  endsequence

  feature_bit_a: assert property (
    (clk_en && query_valid && query_leaf == 32'h7 && query_subleaf == 32'h0)
    |=> (query_done && query_ebx[5]))
    else $error("feature bit missing");

  alias_low_a: assert property (
    s_legacy_wr |=> s.vreg[wr_idx_q][127:0] == $past(req_wr_data[127:0]))
    else $error("narrow alias not written");

  legacy_upper_a: assert property (
    s_legacy_wr |=> s.vreg[wr_idx_q][255:128] == $past(wr_old[255:128]))
    else $error("legacy write touched upper half");

  ext_zero_a: assert property (
    s_ext_narrow_wr |=> (s.vreg[wr_idx_q][255:128] == 128'h0 && wr_done))
    else $error("upper half not zeroed");

  legacy_gp_a: assert property (
    (s_take ##0 (!req_ext_prefix && req_class == safc_pkg::CLS_ALIGNED_MOVE
     && req_addr[3:0] != 4'h0 && !xstate_off && !fp_raise))
    |=> (general_protection_fault && fault_error_code == 16'h0 && !mem_go))
    else $error("misaligned aligned move not faulted");

  free_gp_a: assert property (
    (s_take ##0 (req_ext_prefix && req_class == safc_pkg::CLS_ARITH))
    |=> !general_protection_fault)
    else $error("extended arithmetic faulted on alignment");

  wide_gp_a: assert property (
    (s_take ##0 (req_ext_prefix && req_vlen256 && req_class == safc_pkg::CLS_ALIGNED_MOVE
     && req_addr[4:0] == 5'h10 && !xstate_off && !fp_raise))
    |=> general_protection_fault)
    else $error("32-byte alignment not enforced");

  ac_cond_a: assert property (
    (s_take ##0 (alignment_check_fault == 1'b0)) |=> alignment_check_fault
    |-> ($past(alignment_check_flag) && $past(req_ring) == 2'h3 && $past(s.amctrl)))
    else $error("alignment check without all conditions");

  no_ac_wide_a: assert property (
    (s_take ##0 (req_size_log2 >= 3'h4)) |=> !alignment_check_fault)
    else $error("alignment check on wide reference");

  xm_to_ud_a: assert property (
    (s_take ##0 (fp_raise && !s.osfp)) |=> (undefined_opcode_fault && !simd_fp_exception))
    else $error("unmasked exception not converted");

  int_fp_a: assert property (
    (s_take ##0 (req_fp_kind == safc_pkg::FPK_INT_DATA)) |=> !simd_fp_exception)
    else $error("integer extension raised FP exception");

  xstate_ud_a: assert property (
    (s_take ##0 (req_ext_prefix && s.xmask[2:1] == 2'b00)) |=> undefined_opcode_fault)
    else $error("disabled wide state not undefined");

  fault_block_a: assert property (
    (s_take ##0 fault) |=> (fault_valid && !wr_done && !mem_go && !atomic_ok))
    else $error("faulting instruction had side effects");

endmodule

// ==== safc_top_tb_top.sv ====
// Self-checking bench for the SIMD alignment and FP fault checker.
// Assumes the decode model in its own file and APB answers with one wait state.
`timescale 1ns/1ns
module safc_top_tb_top;
  // ==========================================================
  // Bench signals
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr;
  logic req_valid, req_ext_prefix, req_vlen256, alignment_check_flag, req_wr_en;
  safc_pkg::safc_class_e req_class;
  safc_pkg::safc_fpkind_e req_fp_kind;
  logic [2:0] req_size_log2;
  logic [63:0] req_addr;
  logic [1:0] req_ring;
  logic [5:0] req_fp_flags, req_fp_masks;
  logic [3:0] req_wr_idx, rd_idx = 4'h2;
  logic [255:0] req_wr_data, rd_data;
  logic query_valid = 1'h0, query_done;
  logic [31:0] query_leaf = 32'h0, query_subleaf = 32'h0, query_ebx;
  logic fault_valid, general_protection_fault, alignment_check_fault, undefined_opcode_fault;
  logic simd_fp_exception, mem_go, atomic_ok, wr_done;
  logic [15:0] fault_error_code;
  int checks = 0, fail_count = 0;
  // Expected fault codes: protection, alignment, undefined
  localparam logic [2:0] GP = 3'h4, AC = 3'h2, UD = 3'h1, OK = 3'h0;
  localparam logic [1:0] R3 = safc_pkg::RING_USER;
  localparam logic [255:0] VA = {4{64'h1111_2222_3333_4444}}, VB = {4{64'h5555_6666_7777_8888}};
  // Short names for classes and sizes keep test lines narrow
  localparam safc_pkg::safc_class_e ALM = safc_pkg::CLS_ALIGNED_MOVE, NTL = safc_pkg::CLS_NT_LOAD;
  localparam safc_pkg::safc_class_e UNM = safc_pkg::CLS_UNALIGNED_MOVE, ART = safc_pkg::CLS_ARITH;
  localparam safc_pkg::safc_class_e SCL = safc_pkg::CLS_SCALAR, NON = safc_pkg::CLS_NONE;
  localparam logic [2:0] B8 = safc_pkg::SIZE_8, B16 = safc_pkg::SIZE_16, B32 = safc_pkg::SIZE_32;

  // 25 MHz core clock
  always #20 sys_clk = ~sys_clk;

  // ==========================================================
  // Design and decode model; clock enable held on
  safc_top i_safc_top (.sys_clk, .arst_n, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ext_prefix, .req_vlen256,
    .req_class, .req_size_log2, .req_addr, .req_ring, .alignment_check_flag, .req_fp_kind,
    .req_fp_flags, .req_fp_masks, .req_wr_en, .req_wr_idx, .req_wr_data, .rd_idx, .rd_data,
    .query_valid, .query_leaf, .query_subleaf, .query_ebx, .query_done, .fault_valid,
    .general_protection_fault, .alignment_check_fault, .undefined_opcode_fault,
    .simd_fp_exception, .fault_error_code, .mem_go, .atomic_ok, .wr_done);
  safc_decode_model i_safc_decode_model (.sys_clk, .req_valid, .req_ext_prefix, .req_vlen256,
    .req_class, .req_size_log2, .req_addr, .req_ring, .alignment_check_flag, .req_fp_kind,
    .req_fp_flags, .req_fp_masks, .req_wr_en, .req_wr_idx, .req_wr_data);

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // APB transfer; the answer is taken at the edge where pready is high
  task automatic apb_rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    // Ready is judged at rising edges only; the request stands until then
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    check("apb pready", pready, 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Memory instruction with its expected fault set
  task automatic mem(input logic ext, v256, input safc_pkg::safc_class_e cls,
    input logic [2:0] sz, input logic [63:0] a, input logic [1:0] ring, input logic acf,
    input logic [2:0] exp);
    i_safc_decode_model.issue(ext, v256, cls, sz, a, ring, acf, safc_pkg::FPK_NONE,
      6'h00, 6'h00, 1'h0, '0);
    check("fault gp ac ud", {fault_valid, general_protection_fault, alignment_check_fault,
      undefined_opcode_fault}, {exp != 3'h0, exp});
    check("mem_go", mem_go, exp == 3'h0);
    check("error code", fault_error_code, safc_pkg::ERR_CODE_ZERO);
  endtask

  // FP flag 0 raised with the given masks
  task automatic fp(input safc_pkg::safc_fpkind_e k, input logic [5:0] m, input logic [1:0] exp);
    i_safc_decode_model.issue(1'h0, 1'h0, safc_pkg::CLS_NONE, 3'h0, 64'h0, 2'h0, 1'h0, k,
      6'h01, m, 1'h0, '0);
    check("fp xm ud", {simd_fp_exception, undefined_opcode_fault}, exp);
  endtask

  // Write vector register 2 and read it back one edge later
  task automatic wr(input logic ext, v256, input safc_pkg::safc_class_e cls,
    input logic [63:0] a, input logic [255:0] wd, input logic done, input logic [255:0] exp);
    i_safc_decode_model.issue(ext, v256, cls, safc_pkg::SIZE_16, a, 2'h0, 1'h0,
      safc_pkg::FPK_NONE, 6'h00, 6'h00, 1'h1, wd);
    check("wr_done", wr_done, done);
    @(negedge sys_clk);
    check("vector reg", rd_data, exp);
  endtask

  // ==========================================================
  // Watchdog: the tests take well under 2000 cycles
  initial begin
    #400000;
    fail_count++;
    $display("ERROR watchdog expected end seen hang");
    tally_and_finish();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'h1;
    // Reset values and refused offset
    apb_rw(1'h0, safc_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", rdat, 32'h0);
    apb_rw(1'h0, safc_pkg::REG_XMASK, 32'h0);
    check("xmask reset", rdat, safc_pkg::XMASK_RESET);
    apb_rw(1'h1, 8'h10, 32'hFFFF_FFFF);
    check("unmapped err", rerr, 1'h1);
    apb_rw(1'h0, 8'h10, 32'h0);
    check("unmapped read", {rerr, rdat}, {1'h1, 32'h0});
    $display("test registers done");
    // Feature query through the port and the register window
    @(posedge sys_clk);
    query_valid <= 1'h1;
    query_leaf <= safc_pkg::FEAT_LEAF;
    query_subleaf <= safc_pkg::FEAT_SUBLEAF;
    @(posedge sys_clk);
    query_valid <= 1'h0;
    query_leaf <= ~safc_pkg::FEAT_LEAF;
    @(negedge sys_clk);
    check("query ebx", {query_done, query_ebx & 32'h20}, {1'h1, 32'h20});
    apb_rw(1'h1, safc_pkg::REG_FEATURE, 32'h0000_0007);
    apb_rw(1'h0, safc_pkg::REG_FEATURE, 32'h0);
    check("feature word", rdat & 32'h20, 32'h20);
    mem(1'h1, 1'h0, ART, B16, 64'h0, 2'h0, 1'h0, UD);
    apb_rw(1'h1, safc_pkg::REG_XMASK, 32'h0000_0007);
    apb_rw(1'h0, safc_pkg::REG_XMASK, 32'h0);
    check("xmask enabled", rdat & 32'h6, 32'h6);
    $display("test feature done");
    // Alignment cases with the alignment check armed, then one with it disarmed
    apb_rw(1'h1, safc_pkg::REG_CTRL, 32'h0000_0001);
    mem(1'h0, 1'h0, ALM, B16, 64'h8, R3, 1'h1, GP);
    mem(1'h0, 1'h0, ALM, B16, 64'h10, R3, 1'h1, OK);
    mem(1'h0, 1'h0, UNM, B16, 64'h1, 2'h0, 1'h0, OK);
    mem(1'h0, 1'h0, UNM, B16, 64'hF, R3, 1'h1, OK);
    mem(1'h0, 1'h0, ART, B16, 64'h4, 2'h0, 1'h0, GP);
    mem(1'h1, 1'h1, ART, B32, 64'h3, R3, 1'h1, OK);
    mem(1'h1, 1'h0, ART, B16, 64'h7, 2'h0, 1'h0, OK);
    mem(1'h1, 1'h1, ALM, B32, 64'h10, 2'h0, 1'h0, GP);
    mem(1'h1, 1'h0, ALM, B16, 64'h18, 2'h0, 1'h0, GP);
    mem(1'h1, 1'h0, ALM, B16, 64'h10, 2'h0, 1'h0, OK);
    mem(1'h1, 1'h0, NTL, B16, 64'h20, 2'h0, 1'h0, OK);
    mem(1'h1, 1'h1, NTL, B32, 64'h20, 2'h0, 1'h0, UD);
    mem(1'h0, 1'h0, SCL, B8, 64'h4, R3, 1'h1, AC);
    mem(1'h0, 1'h0, SCL, 3'h1, 64'h1, R3, 1'h1, AC);
    mem(1'h0, 1'h0, SCL, B8, 64'h4, 2'h0, 1'h1, OK);
    mem(1'h0, 1'h0, SCL, B8, 64'h4, R3, 1'h0, OK);
    mem(1'h0, 1'h0, SCL, B8, 64'h8, R3, 1'h1, OK);
    check("atomic small", atomic_ok, 1'h1);
    mem(1'h1, 1'h1, ALM, B32, 64'h20, 2'h0, 1'h0, OK);
    check("atomic wide", atomic_ok, 1'h0);
    apb_rw(1'h1, safc_pkg::REG_CTRL, 32'h0);
    mem(1'h0, 1'h0, SCL, B8, 64'h4, R3, 1'h1, OK);
    $display("test alignment done");
    // Register aliasing and suppressed writes
    wr(1'h1, 1'h1, NON, 64'h0, VA, 1'h1, VA);
    wr(1'h0, 1'h0, NON, 64'h0, VB, 1'h1, {VA[255:128], VB[127:0]});
    wr(1'h1, 1'h0, NON, 64'h0, VA, 1'h1, {128'h0, VA[127:0]});
    wr(1'h0, 1'h0, ART, 64'h8, VB, 1'h0, {128'h0, VA[127:0]});
    $display("test registers file done");
    // FP exceptions with and without the handler flag
    apb_rw(1'h1, safc_pkg::REG_CTRL, 32'h0000_0400);
    for (int k = 1; k < 4; k++) begin
      fp(safc_pkg::safc_fpkind_e'(k), 6'h3E, 2'h2);
      fp(safc_pkg::safc_fpkind_e'(k), 6'h01, 2'h0);
    end
    fp(safc_pkg::FPK_INT_DATA, 6'h00, 2'h0);
    apb_rw(1'h1, safc_pkg::REG_CTRL, 32'h0);
    fp(safc_pkg::FPK_VECTOR, 6'h3E, 2'h1);
    fp(safc_pkg::FPK_VECTOR, 6'h01, 2'h0);
    // Thirteen faults so far, the newest an undefined opcode
    apb_rw(1'h0, safc_pkg::REG_STATUS, 32'h0);
    check("status", rdat, 32'h0000_0D04);
    $display("test fp done");
    tally_and_finish();
  end
endmodule
